//--- inc/tac_pkg.sv
// Notes on behaviour
// - enable bit 15 runs timer; cleared stops counting
// - idle-stop bit 13 halts timer during idle
// - write-block bit 12 ignores counter writes while pending
// - pending flag bit 11 reads busy; synchronous mode zero
// - ext select 9-8: 00 secondary_osc, 01 pin, 10 low_power_rc_osc
// - gate bit 7 gates internal clock; ignored when external
// - prescale 5-4 divides by 1, 8, 64, 256
// - sync bit 2 synchronises external input; internal ignores
// - source bit 1: 0 internal, 1 external select
// - unimplemented control bits read zero
package tac_pkg;

    localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
    localparam logic [7:0]  ADDR_COUNT     = 8'h04;
    localparam logic [7:0]  ADDR_PERIOD    = 8'h08;

    localparam int          BIT_ON         = 15;
    localparam int          BIT_IDLE_STOP  = 13;
    localparam int          BIT_WR_BLOCK   = 12;
    localparam int          BIT_WR_PENDING = 11;
    localparam int          BIT_EXT_SEL    = 8;
    localparam int          BIT_GATE       = 7;
    localparam int          BIT_PRESCALE   = 4;
    localparam int          BIT_EXT_SYNC   = 2;
    localparam int          BIT_CLK_SRC    = 1;

    // writable control bits; bit 11 is status only
    localparam logic [31:0] CONTROL_WMASK  = 32'h0000_B3B6;
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET   = 32'h0000_FFFF;

    localparam logic [1:0]  EXT_SECONDARY  = 2'h0;
    localparam logic [1:0]  EXT_PIN        = 2'h1;
    localparam logic [1:0]  EXT_LOW_POWER  = 2'h2;

    localparam logic [1:0]  PS_DIV1        = 2'h0;
    localparam logic [1:0]  PS_DIV8        = 2'h1;
    localparam logic [1:0]  PS_DIV64       = 2'h2;
    localparam logic [7:0]  PS_LIMIT_1     = 8'h00;
    localparam logic [7:0]  PS_LIMIT_8     = 8'h07;
    localparam logic [7:0]  PS_LIMIT_64    = 8'h3F;
    localparam logic [7:0]  PS_LIMIT_256   = 8'hFF;

    // cycles an asynchronous counter write takes to land
    localparam logic [3:0]  ASYNC_WR_CYCLES = 4'h3;

    typedef struct packed {
        logic       on;
        logic       idle_stop;
        logic       write_block;
        logic [1:0] ext_sel;
        logic       gate_en;
        logic [1:0] prescale;
        logic       ext_sync;
        logic       clock_source;
    } tac_ctrl_t;

    typedef enum {WR_IDLE, WR_PENDING} tac_wr_state_t;

endpackage

//--- rtl/tac_prescaler.sv
module tac_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] prescale,
    output logic            tick_out
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] limit;

    always_comb begin
        case (prescale)
            tac_pkg::PS_DIV1:  limit = tac_pkg::PS_LIMIT_1;
            tac_pkg::PS_DIV8:  limit = tac_pkg::PS_LIMIT_8;
            tac_pkg::PS_DIV64: limit = tac_pkg::PS_LIMIT_64;
            default:           limit = tac_pkg::PS_LIMIT_256;
        endcase
        tick_out = tick_in && (cnt_q >= limit);
        cnt_d    = cnt_q;
        if (clear) begin
            cnt_d = 8'h00;
        end else if (tick_in) begin
            cnt_d = tick_out ? 8'h00 : 8'(cnt_q + 8'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

//--- rtl/tac_timer.sv
module tac_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        IDLE_MODE,
    input  wire logic        GATE_IN,
    input  wire logic        SECONDARY_OSC,
    input  wire logic        TIMER_CLOCK_PIN,
    input  wire logic        LOW_POWER_RC_OSC,
    output logic [WIDTH-1:0] TIMER_COUNT,
    output logic             PERIOD_MATCH
);

    generate
        if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
            $error("tac_timer: WIDTH must lie in 2..32");
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic tac_pkg::tac_ctrl_t to_ctrl(input logic [31:0] w);
        tac_pkg::tac_ctrl_t c;
        c.on           = w[tac_pkg::BIT_ON];
        c.idle_stop    = w[tac_pkg::BIT_IDLE_STOP];
        c.write_block  = w[tac_pkg::BIT_WR_BLOCK];
        c.ext_sel      = w[tac_pkg::BIT_EXT_SEL +: 2];
        c.gate_en      = w[tac_pkg::BIT_GATE];
        c.prescale     = w[tac_pkg::BIT_PRESCALE +: 2];
        c.ext_sync     = w[tac_pkg::BIT_EXT_SYNC];
        c.clock_source = w[tac_pkg::BIT_CLK_SRC];
        return c;
    endfunction

    // bus side state
    logic [31:0]          ctrl_word_q;
    logic [31:0]          ctrl_word_d;
    logic [WIDTH-1:0]     period_q;
    logic [WIDTH-1:0]     period_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic                 ack_q;
    logic                 ack_d;

    // counting state
    logic [WIDTH-1:0]     count_q;
    logic [WIDTH-1:0]     count_d;
    logic [WIDTH-1:0]     wr_value_q;
    logic [WIDTH-1:0]     wr_value_d;
    logic [3:0]           wr_wait_q;
    logic [3:0]           wr_wait_d;
    tac_pkg::tac_wr_state_t wr_state_q;
    tac_pkg::tac_wr_state_t wr_state_d;
    logic                 match_q;
    logic                 match_d;

    // external input path
    logic                 sync1_q;
    logic                 sync2_q;
    logic                 level_prev_q;
    logic                 ext_raw;
    logic                 ext_level;
    logic                 ext_edge;

    tac_pkg::tac_ctrl_t   ctrl;
    logic                 bus_req;
    logic                 wr_ctrl;
    logic                 wr_count;
    logic                 wr_period;
    logic                 async_mode;
    logic                 pending_flag;
    logic                 running;
    logic                 base_tick;
    logic                 ps_tick;
    logic [31:0]          count_word;
    logic [31:0]          merged_count;
    logic [31:0]          merged_period;

    assign ctrl = to_ctrl(ctrl_word_q);

    always_comb begin
        case (ctrl.ext_sel)
            tac_pkg::EXT_SECONDARY: ext_raw = SECONDARY_OSC;
            tac_pkg::EXT_PIN:       ext_raw = TIMER_CLOCK_PIN;
            tac_pkg::EXT_LOW_POWER: ext_raw = LOW_POWER_RC_OSC;
            default:                ext_raw = 1'b0;
        endcase
    end

    // unsynchronised use samples the raw level once for edge detection only
    assign ext_level = ctrl.ext_sync ? sync2_q : ext_raw;
    assign ext_edge  = ext_level && !level_prev_q;

    // async mode: external source without synchroniser
    assign async_mode   = ctrl.clock_source && !ctrl.ext_sync;
    assign pending_flag = async_mode && (wr_state_q == tac_pkg::WR_PENDING);

    assign running = ctrl.on && !(ctrl.idle_stop && IDLE_MODE);

    always_comb begin
        if (ctrl.clock_source) begin
            base_tick = ext_edge;
        end else begin
            base_tick = ctrl.gate_en ? GATE_IN : 1'b1;
        end
    end

    tac_prescaler u_prescaler (
        .clk      (CLK),
        .rst_n    (RST_N),
        .clear    (!running),
        .tick_in  (running && base_tick),
        .prescale (ctrl.prescale),
        .tick_out (ps_tick)
    );

    assign bus_req   = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr_ctrl   = bus_req && WB_WE_I && (WB_ADR_I == tac_pkg::ADDR_CONTROL);
    assign wr_count  = bus_req && WB_WE_I && (WB_ADR_I == tac_pkg::ADDR_COUNT);
    assign wr_period = bus_req && WB_WE_I && (WB_ADR_I == tac_pkg::ADDR_PERIOD);

    assign count_word    = 32'(count_q);
    assign merged_count  = merge(count_word, WB_DAT_I, WB_SEL_I);
    assign merged_period = merge(32'(period_q), WB_DAT_I, WB_SEL_I);

    // bus slave: one wait state, ack for exactly one cycle
    always_comb begin
        ctrl_word_d = ctrl_word_q;
        period_d    = period_q;
        rdata_d     = rdata_q;
        ack_d       = bus_req;
        if (wr_ctrl) begin
            ctrl_word_d = merge(ctrl_word_q, WB_DAT_I, WB_SEL_I)
                          & tac_pkg::CONTROL_WMASK;
        end
        if (wr_period) begin
            period_d = merged_period[WIDTH-1:0];
        end
        if (bus_req && !WB_WE_I) begin
            case (WB_ADR_I)
                tac_pkg::ADDR_CONTROL: begin
                    rdata_d = ctrl_word_q & tac_pkg::CONTROL_WMASK;
                    rdata_d[tac_pkg::BIT_WR_PENDING] = pending_flag;
                end
                tac_pkg::ADDR_COUNT:  rdata_d = count_word;
                tac_pkg::ADDR_PERIOD: rdata_d = 32'(period_q);
                default:              rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_word_q <= tac_pkg::CONTROL_RESET;
            period_q    <= tac_pkg::PERIOD_RESET[WIDTH-1:0];
            rdata_q     <= 32'h0000_0000;
            ack_q       <= 1'b0;
        end else begin
            ctrl_word_q <= ctrl_word_d;
            period_q    <= period_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
        end
    end

    // counter, pending write and period match
    always_comb begin
        count_d    = count_q;
        wr_value_d = wr_value_q;
        wr_wait_d  = wr_wait_q;
        wr_state_d = wr_state_q;
        match_d    = 1'b0;
        if (ps_tick) begin
            if (count_q == period_q) begin
                count_d = '0;
                match_d = 1'b1;
            end else begin
                count_d = WIDTH'(count_q + 1'b1);
            end
        end
        case (wr_state_q)
            tac_pkg::WR_IDLE: begin
                wr_wait_d = 4'h0;
            end
            tac_pkg::WR_PENDING: begin
                if (!async_mode || wr_wait_q <= 4'h1) begin
                    count_d    = wr_value_q;
                    wr_state_d = tac_pkg::WR_IDLE;
                    wr_wait_d  = 4'h0;
                end else begin
                    wr_wait_d = 4'(wr_wait_q - 4'h1);
                end
            end
            default: begin
                wr_state_d = tac_pkg::WR_IDLE;
            end
        endcase
        if (wr_count) begin
            if (!async_mode) begin
                count_d    = merged_count[WIDTH-1:0];
                wr_state_d = tac_pkg::WR_IDLE;
            end else if (!(ctrl.write_block && pending_flag)) begin
                // without the block a new write restarts the pending one
                wr_value_d = merged_count[WIDTH-1:0];
                wr_wait_d  = tac_pkg::ASYNC_WR_CYCLES;
                wr_state_d = tac_pkg::WR_PENDING;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count_q    <= tac_pkg::COUNT_RESET[WIDTH-1:0];
            wr_value_q <= '0;
            wr_wait_q  <= 4'h0;
            wr_state_q <= tac_pkg::WR_IDLE;
            match_q    <= 1'b0;
        end else begin
            count_q    <= count_d;
            wr_value_q <= wr_value_d;
            wr_wait_q  <= wr_wait_d;
            wr_state_q <= wr_state_d;
            match_q    <= match_d;
        end
    end

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1_q      <= 1'b0;
            sync2_q      <= 1'b0;
            level_prev_q <= 1'b0;
        end else begin
            sync1_q      <= ext_raw;
            sync2_q      <= sync1_q;
            level_prev_q <= ext_level;
        end
    end

    assign WB_DAT_O     = rdata_q;
    assign WB_ACK_O     = ack_q;
    assign TIMER_COUNT  = count_q;
    assign PERIOD_MATCH = match_q;

endmodule

//--- sim/tac_timer_props.sv
module tac_timer_props #(
    parameter int WIDTH = 16
) (
    input wire logic             CLK,
    input wire logic             RST_N,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic             WB_WE_I,
    input wire logic [7:0]       WB_ADR_I,
    input wire logic [3:0]       WB_SEL_I,
    input wire logic [31:0]      WB_DAT_I,
    input wire logic [31:0]      WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic             IDLE_MODE,
    input wire logic             GATE_IN,
    input wire logic             SECONDARY_OSC,
    input wire logic             TIMER_CLOCK_PIN,
    input wire logic             LOW_POWER_RC_OSC,
    input wire logic [WIDTH-1:0] TIMER_COUNT,
    input wire logic             PERIOD_MATCH
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [2:0]  hold_q;
    logic [2:0]  hold_d;
    assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // shadow of the control register; hold masks count moves caused by writes
    always_comb begin
        ctl_d = ctl_q;
        hold_d = hold_q - {2'h0, hold_q != 3'h0};
        if (take && WB_WE_I) begin
            hold_d = 3'h6;
            if (WB_ADR_I == tac_pkg::ADDR_CONTROL) begin
                for (int b = 0; b < 4; b++)
                    if (WB_SEL_I[b]) ctl_d[8*b+:8] = WB_DAT_I[8*b+:8];
                ctl_d = ctl_d & tac_pkg::CONTROL_WMASK;
            end
        end
    end
    always_ff @(posedge CLK) begin
        ctl_q <= RST_N ? ctl_d : 32'h0000_0000;
        hold_q <= RST_N ? hold_d : 3'h0;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    chk_ack_next: assert property (take |=> WB_ACK_O) else $error("ack missing");
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    chk_unimpl_zero: assert property (
        WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 8'h00) |-> (WB_DAT_O & ~32'h0000_BBB6) == 0)
        else $error("unimplemented control bit set");
    chk_sync_nopend: assert property (
        WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 8'h00) && !(ctl_q[1] && !ctl_q[2])
        |-> !WB_DAT_O[11]) else $error("pending flag in sync mode");
    chk_unmapped_zero: assert property (
        WB_ACK_O && $past(!WB_WE_I && WB_ADR_I > 8'h08) |-> WB_DAT_O == 0)
        else $error("unmapped read not zero");
    chk_off_holds: assert property (
        (!ctl_q[15] && hold_q == 0) [*4] |-> $stable(TIMER_COUNT)) else $error("count while off");
    chk_idle_holds: assert property (
        (ctl_q[13] && IDLE_MODE && hold_q == 0) [*4] |-> $stable(TIMER_COUNT))
        else $error("count while idle");
    chk_div1_steps: assert property (
        (ctl_q[15] && (ctl_q & 32'h0000_00B2) == 0 && !IDLE_MODE && hold_q == 0) [*3]
        |-> TIMER_COUNT != $past(TIMER_COUNT)) else $error("internal div1 not counting");
    chk_count_step: assert property (
        hold_q == 0 && TIMER_COUNT != $past(TIMER_COUNT)
        |-> TIMER_COUNT == $past(TIMER_COUNT) + 1'b1 || TIMER_COUNT == 0)
        else $error("count jumped");
    chk_match_wraps: assert property (
        PERIOD_MATCH && hold_q == 0 |-> TIMER_COUNT == 0) else $error("match without wrap");
endmodule

bind tac_timer tac_timer_props #(.WIDTH(WIDTH)) tac_timer_props_i (
    .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .IDLE_MODE(IDLE_MODE), .GATE_IN(GATE_IN),
    .SECONDARY_OSC(SECONDARY_OSC), .TIMER_CLOCK_PIN(TIMER_CLOCK_PIN),
    .LOW_POWER_RC_OSC(LOW_POWER_RC_OSC), .TIMER_COUNT(TIMER_COUNT),
    .PERIOD_MATCH(PERIOD_MATCH));

//--- sim/tac_ext_src.sv
module tac_ext_src (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [1:0] src,
    input  wire logic [7:0] pulses,
    output logic      [2:0] lines,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q = 8'h00;
    logic [2:0] ph_q = 3'h0;
    // edges spaced eight cycles apart so a synchroniser never merges two
    always_ff @(posedge clk) begin
        ph_q <= ph_q + 3'h1;
        if (start) left_q <= pulses;
        else if (ph_q == 3'h7 && busy) left_q <= left_q - 8'h01;
    end
    assign busy = left_q != 8'h00;
    assign lines = {2'h0, busy & ph_q[2]} << src;
endmodule

//--- sim/tac_timer_tb.sv
module tac_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic        idle = 1'b0;
    logic        gate = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  src = 2'h0;
    logic [31:0] dat;
    logic [31:0] rd;
    logic        ack;
    logic [2:0]  ext;
    logic        busy;
    int          divs[4] = '{1, 8, 64, 256};
    int          mismatches = 0;
    int          compares = 0;
    tac_timer tac_timer_i (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(dat),
        .WB_ACK_O(ack), .IDLE_MODE(idle), .GATE_IN(gate), .SECONDARY_OSC(ext[0]),
        .TIMER_CLOCK_PIN(ext[1]), .LOW_POWER_RC_OSC(ext[2]), .TIMER_COUNT(),
        .PERIOD_MATCH());
    tac_ext_src tac_ext_src_i (.clk(clk), .start(go), .src(src), .pulses(8'h05),
        .lines(ext), .busy(busy));
    initial forever #5 clk = ~clk;
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // entered just after a rising edge; ack and read data are taken at the edge that sees ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), rd, exp);
    endtask
    task automatic cnt_in(input int lo, input int hi);
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk("count range", {31'h0, rd >= lo && rd <= hi}, 32'h0000_0001);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(8'h00, 32'h0000_0000);
        rchk(8'h08, 32'h0000_FFFF);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF);
        rchk(8'h00, 32'h0000_B3B6);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rchk(8'h0C, 32'h0000_0000);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, 8'h00, 32'h0000_0000);
            bus(1'b1, 8'h04, 32'h0000_0000);
            bus(1'b1, 8'h00, 32'h0000_8000 | (p << 4));
            repeat (8 * divs[p]) @(posedge clk);
            bus(1'b1, 8'h00, 32'h0000_0000);
            cnt_in(8, 12);
            bus(1'b0, 8'h04, 32'h0000_0000);
            repeat (10) @(posedge clk);
            rchk(8'h04, rd);
        end
        bus(1'b1, 8'h04, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_8080);
        repeat (20) @(posedge clk);
        rchk(8'h04, 32'h0000_0000);
        gate <= 1'b1;
        repeat (5) @(posedge clk);
        cnt_in(1, 30);
        idle <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_A000);
        bus(1'b1, 8'h04, 32'h0000_0000);
        repeat (20) @(posedge clk);
        rchk(8'h04, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_8000);
        cnt_in(1, 30);
        idle <= 1'b0;
        gate <= 1'b0;
        // gate bit stays set to show an external source ignores it
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 8'h00, 32'h0000_0000);
            bus(1'b1, 8'h04, 32'h0000_0000);
            bus(1'b1, 8'h00, 32'h0000_8082 | ((s % 4) << 8) | ((s / 4) << 2));
            src <= (s % 4 == 3) ? 2'h0 : 2'(s % 4);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            while (busy) @(posedge clk);
            repeat (6) @(posedge clk);
            rchk(8'h04, (s % 4 == 3) ? 32'h0 : 32'h5);
        end
        // short period so the count wraps and the match pulse is seen by the checker
        bus(1'b1, 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'h0000_0003);
        bus(1'b1, 8'h00, 32'h0000_8000);
        repeat (20) @(posedge clk);
        cnt_in(0, 3);
        rchk(8'h08, 32'h0000_0003);
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, 8'h00, 32'h0000_8302 | (b << 12));
            bus(1'b1, 8'h04, 32'h0000_1234);
            bus(1'b1, 8'h04, 32'h0000_5555);
            repeat (8) @(posedge clk);
            rchk(8'h04, b ? 32'h0000_1234 : 32'h0000_5555);
            rchk(8'h00, 32'h0000_8302 | (b << 12));
        end
        bus(1'b1, 8'h04, 32'h0000_0042);
        rchk(8'h00, 32'h0000_9B02);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
